// *** core/iseb_pkg.sv ***
// Constants for the interrupt source enable bank: register indices, byte
// addresses, field positions, reset values and bus states.
// Assumes a 32-bit Avalon-MM slave port with byte addressing.
package iseb_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int unsigned NUM_REGS = 5;
  localparam int unsigned REG_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W = 10;
  localparam int unsigned DATA_W = 32;

  //////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SRC_EN_FRAME_RX_STATUS = 10'h105;
  localparam logic [IDX_W-1:0] IDX_SRC_EN_RX_TX_PROGRESS = 10'h106;
  localparam logic [IDX_W-1:0] IDX_SRC_EN_CANCEL_CCA = 10'h107;
  localparam logic [IDX_W-1:0] IDX_SRC_EN_TRANSMIT = 10'h108;
  localparam logic [IDX_W-1:0] IDX_SRC_EN_RECEIVE = 10'h109;
  // Flag (status, write one to clear) registers, same layouts
  localparam logic [IDX_W-1:0] IDX_FLAG_BASE = 10'h115;
  // Output enable (mask) registers, same layouts
  localparam logic [IDX_W-1:0] IDX_OUT_EN_BASE = 10'h125;
  // Read-only summary of pending registers and the interrupt line
  localparam logic [IDX_W-1:0] IDX_SUMMARY = 10'h130;
  localparam int unsigned SUMMARY_IRQ_BIT = 8;

  //////////////////////////////////////////////////////////////////////////
  // Reset values and writable bits
  localparam logic [REG_W-1:0] SRC_EN_RST = 8'h00;
  localparam logic [REG_W-1:0] OUT_EN_RST = 8'h00;
  localparam logic [REG_W-1:0] FLAG_RST = 8'h00;
  // Third register: bits 6 and 5 unassigned, held at zero
  localparam logic [NUM_REGS-1:0][REG_W-1:0] SRC_EN_WMASK =
    {8'hff, 8'hff, 8'h9f, 8'hff, 8'hff};

  //////////////////////////////////////////////////////////////////////////
  // Field positions, register 1 (frame rx status)
  localparam int unsigned R1_FRAME_TX_DONE = 7;
  localparam int unsigned R1_RX_LEVEL = 6;
  localparam int unsigned R1_MODE_SWITCH_RX_DONE = 5;
  localparam int unsigned R1_RX_OVERRUN = 4;
  localparam int unsigned R1_ADDR_FILTER = 3;
  localparam int unsigned R1_FRAME_LEN = 2;
  localparam int unsigned R1_BANK1_RX_DONE = 1;
  localparam int unsigned R1_BANK0_RX_DONE = 0;
  // Register 2 (rx tx progress)
  localparam int unsigned R2_PREAMBLE_DETECT = 7;
  localparam int unsigned R2_CCA_DONE = 6;
  localparam int unsigned R2_GAIN_CTRL_DONE = 5;
  localparam int unsigned R2_RX_BYTE_COUNT = 4;
  localparam int unsigned R2_FRAME_RX_DONE = 3;
  localparam int unsigned R2_RX_START = 2;
  localparam int unsigned R2_TX_START = 1;
  localparam int unsigned R2_TX_BYTE_COUNT = 0;
  // Register 3 (cancel cca)
  localparam int unsigned R3_RX_CANCEL = 7;
  localparam int unsigned R3_TX_UNDERRUN = 4;
  localparam int unsigned R3_AUTO_RX_TIMEOUT = 3;
  localparam int unsigned R3_CHANNEL_CLEAR = 2;
  localparam int unsigned R3_CHANNEL_CHECK_LIMIT = 1;
  localparam int unsigned R3_CARRIER_SENSE = 0;
  // Register 4 (transmit)
  localparam int unsigned R4_FRAME_TX_DONE = 7;
  localparam int unsigned R4_FRAME_SYNC_TX_DONE = 6;
  localparam int unsigned R4_TX_START = 5;
  localparam int unsigned R4_ACCESS_BACKOFF_DONE = 4;
  localparam int unsigned R4_TX_UNDERRUN = 3;
  localparam int unsigned R4_TX_BYTE_COUNT = 2;
  localparam int unsigned R4_BANK1_TX_DONE = 1;
  localparam int unsigned R4_BANK0_TX_DONE = 0;
  // Register 5 (receive)
  localparam int unsigned R5_AUTO_RX_TIMEOUT = 7;
  localparam int unsigned R5_RX_LEVEL = 6;
  localparam int unsigned R5_FRAME_RX_DONE = 5;
  localparam int unsigned R5_FRAME_LEN = 4;
  localparam int unsigned R5_RX_START_ALT = 3;
  localparam int unsigned R5_PREAMBLE_DETECT = 2;
  localparam int unsigned R5_CARRIER_SENSE = 1;
  localparam int unsigned R5_GAIN_CTRL_DONE = 0;

  //////////////////////////////////////////////////////////////////////////
  // Bus answer states
  typedef enum logic [1:0]
  {
    ISEB_ST_IDLE = 2'b01,
    ISEB_ST_ACK = 2'b10
  } iseb_bus_st_t;

endpackage : iseb_pkg

// *** core/iseb_flag_if.sv ***
// Carrier between the register file and one flag bank.
// Assumes all signals on the system clock.
`timescale 1ns/10ps
interface iseb_flag_if;
  logic [7:0] src_en;
  logic [7:0] out_en;
  logic [7:0] evt_req;
  logic [7:0] clr;
  logic [7:0] flag;
  logic pend;

  // Flag bank side
  modport bank
  (
    input src_en,
    input out_en,
    input evt_req,
    input clr,
    output flag,
    output pend
  );

  // Register file side
  modport ctrl
  (
    output src_en,
    output out_en,
    output evt_req,
    output clr,
    input flag,
    input pend
  );
endinterface : iseb_flag_if

// *** core/iseb_flag_bank.sv ***
// One bank of eight interrupt source flags with their gating.
// Assumes event requests are one-cycle pulses on the system clock.
`timescale 1ns/10ps
module iseb_flag_bank
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Control and status
  iseb_flag_if.bank fb
);

  logic [7:0] flag_reg;
  logic [7:0] flag_next;

  //////////////////////////////////////////////////////////////////////////
  // Per-bit set and clear
  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_bit
      always_comb
      begin
        flag_next[b] = (flag_reg[b] & ~fb.clr[b]) |
                       (fb.evt_req[b] & fb.src_en[b]);
      end
    end
  endgenerate

  // Flag registers
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      flag_reg <= iseb_pkg::FLAG_RST;
    else
      flag_reg <= flag_next;
  end

  assign fb.pend = |(flag_reg & fb.out_en);
  assign fb.flag = flag_reg;

endmodule : iseb_flag_bank

// *** core/iseb_top.sv ***
// Interrupt source enable bank: five source enable registers, matching
// flag and output enable registers, Avalon-MM slave, one interrupt line.
// Assumes event requests come from logic on clk_sys_i, one-cycle pulses.
//
// How it works
// - An enabled event sets its source flag to one.
// - Enable bit zero blocks requests for its source, one permits them.
// - All five source enable registers read zero after reset.
// - First register: tx done, rx level, mode switch, overrun, addr, len.
// - Second register: preamble, CCA, gain, byte counts, rx, tx start.
// - Third register: cancel, underrun, rx timeout, clear, limit, sense.
// - Fourth register: tx done, sync, start, backoff, underrun, banks.
// - Fifth register: timeout, level, rx done, length, start, sense, gain.
// - Output enable bit routes a set flag onto the interrupt pin.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/10ps
module iseb_top
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Avalon-MM register slave
  input wire logic [iseb_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [iseb_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [iseb_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Radio event requests, register r bit b at index r*8+b
  input wire logic [iseb_pkg::NUM_REGS*iseb_pkg::REG_W-1:0] evt_req_i,
  // Interrupt output pin, level
  output logic irq_output_pin_o
);

  localparam int unsigned NR = iseb_pkg::NUM_REGS;
  localparam int unsigned RW = iseb_pkg::REG_W;

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  iseb_pkg::iseb_bus_st_t st_reg;
  iseb_pkg::iseb_bus_st_t st_next;
  logic wait_reg;
  logic wait_next;
  logic [iseb_pkg::DATA_W-1:0] rdata_reg;
  logic [iseb_pkg::DATA_W-1:0] rdata_next;
  logic [iseb_pkg::DATA_W-1:0] rd_mux;
  logic irq_reg;
  logic irq_next;
  logic [NR-1:0][RW-1:0] src_en_reg;
  logic [NR-1:0][RW-1:0] src_en_next;
  logic [NR-1:0][RW-1:0] src_en_gate;
  logic [NR-1:0][RW-1:0] out_en_reg;
  logic [NR-1:0][RW-1:0] out_en_next;
  logic [NR-1:0][RW-1:0] flag_vec;
  logic [NR-1:0] pend_vec;
  logic [NR-1:0] sel_src;
  logic [NR-1:0] sel_flag;
  logic [NR-1:0] sel_oen;
  logic sel_sum;
  logic aligned;
  logic [iseb_pkg::IDX_W-1:0] idx;
  logic req;
  logic commit_wr;
  logic [RW-1:0] wbyte;

  //////////////////////////////////////////////////////////////////////////
  // Address decode
  assign idx = avs_address_i[iseb_pkg::ADDR_W-1:2];
  assign aligned = (avs_address_i[1:0] == 2'h0);
  assign sel_sum = aligned & (idx == iseb_pkg::IDX_SUMMARY);
  assign req = avs_read_i | avs_write_i;
  assign wbyte = avs_writedata_i[RW-1:0];

  // Write lands at the edge where waitrequest is sampled low
  assign commit_wr = (st_reg == iseb_pkg::ISEB_ST_ACK) & avs_write_i &
                     avs_byteenable_i[0];

  //////////////////////////////////////////////////////////////////////////
  // Bus answer machine: one wait cycle, then one answer cycle
  always_comb
  begin
    st_next = st_reg;
    wait_next = 1'b1;
    unique case (st_reg)
      iseb_pkg::ISEB_ST_IDLE:
      begin
        if (req)
        begin
          st_next = iseb_pkg::ISEB_ST_ACK;
          wait_next = 1'b0;
        end
      end
      iseb_pkg::ISEB_ST_ACK:
      begin
        // Request completes here; release before the next one
        st_next = iseb_pkg::ISEB_ST_IDLE;
        wait_next = 1'b1;
      end
      default:
      begin
        st_next = iseb_pkg::ISEB_ST_IDLE;
        wait_next = 1'b1;
      end
    endcase
  end

  // Bus answer registers
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= iseb_pkg::ISEB_ST_IDLE;
      wait_reg <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
      wait_reg <= wait_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Named source enable fields, regrouped into the gate of each bank
  // First register
  wire frame_tx_done_src_en_1 = src_en_reg[0][iseb_pkg::R1_FRAME_TX_DONE];
  wire rx_level_src_en_1 = src_en_reg[0][iseb_pkg::R1_RX_LEVEL];
  wire mode_switch_rx_done_src_en_1 =
    src_en_reg[0][iseb_pkg::R1_MODE_SWITCH_RX_DONE];
  wire rx_overrun_src_en_1 = src_en_reg[0][iseb_pkg::R1_RX_OVERRUN];
  wire addr_filter_src_en_1 = src_en_reg[0][iseb_pkg::R1_ADDR_FILTER];
  wire frame_len_src_en_1 = src_en_reg[0][iseb_pkg::R1_FRAME_LEN];
  wire bank1_rx_done_src_en_1 = src_en_reg[0][iseb_pkg::R1_BANK1_RX_DONE];
  wire bank0_rx_done_src_en_1 = src_en_reg[0][iseb_pkg::R1_BANK0_RX_DONE];
  assign src_en_gate[0] = {frame_tx_done_src_en_1, rx_level_src_en_1,
    mode_switch_rx_done_src_en_1, rx_overrun_src_en_1, addr_filter_src_en_1,
    frame_len_src_en_1, bank1_rx_done_src_en_1, bank0_rx_done_src_en_1};

  wire preamble_detect_src_en_2 = src_en_reg[1][iseb_pkg::R2_PREAMBLE_DETECT];
  wire cca_done_src_en_2 = src_en_reg[1][iseb_pkg::R2_CCA_DONE];
  wire gain_ctrl_done_src_en_2 = src_en_reg[1][iseb_pkg::R2_GAIN_CTRL_DONE];
  wire rx_byte_count_src_en_2 = src_en_reg[1][iseb_pkg::R2_RX_BYTE_COUNT];
  wire frame_rx_done_src_en_2 = src_en_reg[1][iseb_pkg::R2_FRAME_RX_DONE];
  wire rx_start_src_en_2 = src_en_reg[1][iseb_pkg::R2_RX_START];
  wire tx_start_src_en_2 = src_en_reg[1][iseb_pkg::R2_TX_START];
  wire tx_byte_count_src_en_2 = src_en_reg[1][iseb_pkg::R2_TX_BYTE_COUNT];
  assign src_en_gate[1] = {preamble_detect_src_en_2, cca_done_src_en_2,
    gain_ctrl_done_src_en_2, rx_byte_count_src_en_2, frame_rx_done_src_en_2,
    rx_start_src_en_2, tx_start_src_en_2, tx_byte_count_src_en_2};

  // Third register, bits 6 and 5 never gate a flag
  wire rx_cancel_src_en_3 = src_en_reg[2][iseb_pkg::R3_RX_CANCEL];
  wire tx_underrun_src_en_3 = src_en_reg[2][iseb_pkg::R3_TX_UNDERRUN];
  wire auto_rx_timeout_src_en_3 = src_en_reg[2][iseb_pkg::R3_AUTO_RX_TIMEOUT];
  wire channel_clear_src_en_3 = src_en_reg[2][iseb_pkg::R3_CHANNEL_CLEAR];
  wire channel_check_limit_src_en_3 =
    src_en_reg[2][iseb_pkg::R3_CHANNEL_CHECK_LIMIT];
  wire carrier_sense_src_en_3 = src_en_reg[2][iseb_pkg::R3_CARRIER_SENSE];
  assign src_en_gate[2] = {rx_cancel_src_en_3, 2'h0, tx_underrun_src_en_3,
    auto_rx_timeout_src_en_3, channel_clear_src_en_3,
    channel_check_limit_src_en_3, carrier_sense_src_en_3};

  wire frame_tx_done_src_en_4 = src_en_reg[3][iseb_pkg::R4_FRAME_TX_DONE];
  wire frame_sync_tx_done_src_en_4 =
    src_en_reg[3][iseb_pkg::R4_FRAME_SYNC_TX_DONE];
  wire tx_start_src_en_4 = src_en_reg[3][iseb_pkg::R4_TX_START];
  wire access_backoff_done_src_en_4 =
    src_en_reg[3][iseb_pkg::R4_ACCESS_BACKOFF_DONE];
  wire tx_underrun_src_en_4 = src_en_reg[3][iseb_pkg::R4_TX_UNDERRUN];
  wire tx_byte_count_src_en_4 = src_en_reg[3][iseb_pkg::R4_TX_BYTE_COUNT];
  wire bank1_tx_done_src_en_4 = src_en_reg[3][iseb_pkg::R4_BANK1_TX_DONE];
  wire bank0_tx_done_src_en_4 = src_en_reg[3][iseb_pkg::R4_BANK0_TX_DONE];
  assign src_en_gate[3] = {frame_tx_done_src_en_4,
    frame_sync_tx_done_src_en_4, tx_start_src_en_4,
    access_backoff_done_src_en_4, tx_underrun_src_en_4,
    tx_byte_count_src_en_4, bank1_tx_done_src_en_4, bank0_tx_done_src_en_4};

  wire auto_rx_timeout_src_en_5 = src_en_reg[4][iseb_pkg::R5_AUTO_RX_TIMEOUT];
  wire rx_level_src_en_5 = src_en_reg[4][iseb_pkg::R5_RX_LEVEL];
  wire frame_rx_done_src_en_5 = src_en_reg[4][iseb_pkg::R5_FRAME_RX_DONE];
  wire frame_len_src_en_5 = src_en_reg[4][iseb_pkg::R5_FRAME_LEN];
  wire rx_start_alt_src_en_5 = src_en_reg[4][iseb_pkg::R5_RX_START_ALT];
  wire preamble_detect_src_en_5 = src_en_reg[4][iseb_pkg::R5_PREAMBLE_DETECT];
  wire carrier_sense_src_en_5 = src_en_reg[4][iseb_pkg::R5_CARRIER_SENSE];
  wire gain_ctrl_done_src_en_5 = src_en_reg[4][iseb_pkg::R5_GAIN_CTRL_DONE];
  assign src_en_gate[4] = {auto_rx_timeout_src_en_5, rx_level_src_en_5,
    frame_rx_done_src_en_5, frame_len_src_en_5, rx_start_alt_src_en_5,
    preamble_detect_src_en_5, carrier_sense_src_en_5, gain_ctrl_done_src_en_5};

  //////////////////////////////////////////////////////////////////////////
  // Per-register decode, storage and flag bank
  genvar r;
  generate
    for (r = 0; r < NR; r++)
    begin : g_reg
      iseb_flag_if fif ();

      // Decode of the three registers of this group
      assign sel_src[r] = aligned &
        (idx == iseb_pkg::IDX_W'(iseb_pkg::IDX_SRC_EN_FRAME_RX_STATUS + r));
      assign sel_flag[r] = aligned &
        (idx == iseb_pkg::IDX_W'(iseb_pkg::IDX_FLAG_BASE + r));
      assign sel_oen[r] = aligned &
        (idx == iseb_pkg::IDX_W'(iseb_pkg::IDX_OUT_EN_BASE + r));

      always_comb
      begin
        src_en_next[r] = src_en_reg[r];
        if (commit_wr && sel_src[r])
        begin
          src_en_next[r] = wbyte & iseb_pkg::SRC_EN_WMASK[r];
        end
      end

      always_comb
      begin
        out_en_next[r] = out_en_reg[r];
        if (commit_wr && sel_oen[r])
          out_en_next[r] = wbyte;
      end

      always_ff @(posedge clk_sys_i)
      begin
        if (!rst_n_i)
        begin
          src_en_reg[r] <= iseb_pkg::SRC_EN_RST;
          out_en_reg[r] <= iseb_pkg::OUT_EN_RST;
        end
        else
        begin
          src_en_reg[r] <= src_en_next[r];
          out_en_reg[r] <= out_en_next[r];
        end
      end

      // Bank hookup; clear is write one to the flag register
      assign fif.src_en = src_en_gate[r];
      assign fif.out_en = out_en_reg[r];
      assign fif.evt_req = evt_req_i[r*RW +: RW];
      assign fif.clr = (commit_wr && sel_flag[r]) ? wbyte : 8'h00;
      assign flag_vec[r] = fif.flag;
      assign pend_vec[r] = fif.pend;

      iseb_flag_bank u_bank
      (
        .clk_sys_i (clk_sys_i),
        .rst_n_i (rst_n_i),
        .fb (fif)
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Read data mux; unmapped addresses read zero
  always_comb
  begin
    rd_mux = '0;
    for (int i = 0; i < NR; i++)
    begin
      if (sel_src[i])
        rd_mux[RW-1:0] = src_en_reg[i];
      if (sel_flag[i])
        rd_mux[RW-1:0] = flag_vec[i];
      if (sel_oen[i])
        rd_mux[RW-1:0] = out_en_reg[i];
    end
    if (sel_sum)
    begin
      rd_mux[NR-1:0] = pend_vec;
      rd_mux[iseb_pkg::SUMMARY_IRQ_BIT] = irq_reg;
    end
  end

  // Read data captured on the wait cycle, stands through the answer
  always_comb
  begin
    rdata_next = rdata_reg;
    if ((st_reg == iseb_pkg::ISEB_ST_IDLE) && avs_read_i)
      rdata_next = rd_mux;
  end

  // Read data register
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt line: any unmasked flag set
  always_comb
  begin
    irq_next = |pend_vec;
  end

  // Interrupt register
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      irq_reg <= 1'b0;
    else
      irq_reg <= irq_next;
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign irq_output_pin_o = irq_reg;

endmodule : iseb_top

// *** dv/iseb_checker.sv ***
// Checker for the bus answer and the interrupt line of the enable bank.
// Assumes it is bound to iseb_top and sees only its ports.
`timescale 1ns/10ps
module iseb_checker
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Register slave
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [iseb_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Events and interrupt
  input wire logic [iseb_pkg::NUM_REGS*iseb_pkg::REG_W-1:0] evt_req_i,
  input wire logic irq_output_pin_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer
  property p_rst_idle;
    disable iff (1'h0) !rst_n_i |=> avs_waitrequest_o && !irq_output_pin_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("busy in reset");
  property p_ack_lat;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("late answer");
  property p_ack_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("long answer");
  property p_ack_cause;
    $fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_rd_hold;
    avs_waitrequest_o && $past(rst_n_i) |-> $stable(avs_readdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("data moved");
  property p_rd_upper;
    avs_readdata_o[31:9] == 23'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper bits");

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt line
  property p_irq_rise;
    $rose(irq_output_pin_o) |-> $past(|evt_req_i, 2) ||
      $past(avs_write_i && !avs_waitrequest_o, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("stray irq");
  property p_irq_fall;
    $fell(irq_output_pin_o) |-> $past(avs_write_i && !avs_waitrequest_o, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq lost");
endmodule : iseb_checker

bind iseb_top iseb_checker u_iseb_checker
(
  .clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .evt_req_i(evt_req_i),
  .irq_output_pin_o(irq_output_pin_o)
);

// *** dv/iseb_host_model.sv ***
// Host side model that watches the interrupt pin.
// Assumes a level interrupt on the system clock.
`timescale 1ns/10ps
module iseb_host_model
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Interrupt pin and its rise count
  input wire logic irq_output_pin_i,
  output int unsigned rise_cnt_o
);
  logic irq_q;

  always @(posedge clk_sys_i)
  begin
    irq_q <= irq_output_pin_i;
    if (!rst_n_i)
      rise_cnt_o <= 0;
    else if (irq_output_pin_i === 1'h1 && irq_q === 1'h0)
      rise_cnt_o <= rise_cnt_o + 1;
  end
endmodule : iseb_host_model

// *** dv/testbench.sv ***
// Self-checking bench for the interrupt source enable bank.
// Assumes the host model watches the interrupt pin.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
  fail_count++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module testbench;
  localparam int unsigned SE = iseb_pkg::IDX_SRC_EN_FRAME_RX_STATUS;
  localparam int unsigned FB = iseb_pkg::IDX_FLAG_BASE;
  localparam int unsigned OE = iseb_pkg::IDX_OUT_EN_BASE;
  logic clk_sys_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [11:0] avs_address_i = 12'h0;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [39:0] evt_req_i = 40'h0;
  logic irq_output_pin_o;
  int unsigned rise_cnt;
  int fail_count = 0;
  int checks = 0;
  logic [31:0] exp_q[$];
  logic [31:0] note;
  logic [7:0] e, d, v;
  logic [39:0] ev;

  // Design and host model
  iseb_top u_iseb_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .evt_req_i(evt_req_i),
    .irq_output_pin_o(irq_output_pin_o));
  iseb_host_model u_iseb_host_model (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .irq_output_pin_i(irq_output_pin_o),
    .rise_cnt_o(rise_cnt));

  // Clock
  initial
  begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input int unsigned ix, input logic wr,
    input logic [7:0] dat);
    avs_address_i <= 12'(ix * 4);
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_writedata_i <= {24'h0, dat};
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'h0)
    begin
      @(posedge clk_sys_i);
    end
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
    @(posedge clk_sys_i);
  endtask : bus

  // Read with the expected byte noted first
  task automatic rd(input int unsigned ix, input logic [7:0] x);
    exp_q.push_back({24'h0, x});
    bus(ix, 1'h0, 8'h00);
  endtask : rd

  // Read data monitor
  always @(posedge clk_sys_i)
  begin
    if (avs_read_i && avs_waitrequest_o === 1'h0)
    begin
      note = exp_q.pop_front();
      `CHK("readdata", note, avs_readdata_o)
    end
  end

  // Watchdog
  initial
  begin
    #5000000;
    fail_count++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'ha847));
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    @(posedge clk_sys_i);
    // Reset values and an unmapped place
    for (int r = 0; r < 5; r++)
    begin
      rd(SE + r, 8'h00);
      rd(FB + r, 8'h00);
      rd(OE + r, 8'h00);
    end
    rd(0, 8'h00);
    // Per register: random enables, random events on all registers
    for (int r = 0; r < 5; r++)
    begin
      e = 8'($urandom);
      ev = 40'({$urandom, $urandom});
      v = ev[r*8 +: 8];
      // zero in bits 6 and 5
      d = (r == 2) ? (e & 8'h9f) : e;
      bus(SE + r, 1'h1, d);
      rd(SE + r, d);
      evt_req_i <= ev;
      @(posedge clk_sys_i);
      evt_req_i <= 40'h0;
      bus(SE + r, 1'h1, (r == 2) ? 8'h9f : 8'hff);
      rd(FB + r, v & d);
      bus(FB + r, 1'h1, 8'hff);
      rd(FB + r, 8'h00);
      bus(SE + r, 1'h1, 8'h00);
    end
    for (int r = 0; r < 5; r++)
      rd(FB + r, 8'h00);
    // Masked flag keeps the pin low, unmasking raises it
    bus(SE + 3, 1'h1, 8'h80);
    evt_req_i <= 40'h0080000000;
    @(posedge clk_sys_i);
    evt_req_i <= 40'h0;
    repeat (3) @(posedge clk_sys_i);
    `CHK("irq masked", 1'h0, irq_output_pin_o)
    bus(OE + 3, 1'h1, 8'h80);
    repeat (2) @(posedge clk_sys_i);
    `CHK("irq on", 1'h1, irq_output_pin_o)
    `CHK("irq rises", 1, rise_cnt)
    // Summary shows the pending fourth register and the line
    exp_q.push_back((32'h1 << iseb_pkg::SUMMARY_IRQ_BIT) | (32'h1 << 3));
    bus(iseb_pkg::IDX_SUMMARY, 1'h0, 8'h00);
    rd(OE + 3, 8'h80);
    bus(FB + 3, 1'h1, 8'h80);
    repeat (2) @(posedge clk_sys_i);
    `CHK("irq off", 1'h0, irq_output_pin_o)
    // Reset in mid-run clears enables and masks again
    rst_n_i <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    @(posedge clk_sys_i);
    rd(SE + 3, 8'h00);
    rd(OE + 3, 8'h00);
    wrap_up();
  end
endmodule : testbench
